// ===== rtl/itm_channel.sv
/*
 integrator and time measure channel with an AXI4-Lite register slave.
 assumes sinc words arrive as one-cycle valid pulses on aclk, and that
 hold strobes, modulator clock and modulator bit are asynchronous pins.
*/
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module itm_channel #(
   parameter int ADDR_W = 8,
   parameter int MAX_RATIO = 128
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] sinc_data,
   input wire logic sinc_valid,
   input wire logic sinc_enable,
   input wire logic mod_clk,
   input wire logic mod_data,
   input wire logic [1:0] hold_strobe_input,
   input wire logic phase_cal_done,
   output logic [31:0] data_out,
   output logic data_new,
   output logic [15:0] time_out,
   output logic demod_active,
   output logic sync_start_pulse,
   output logic accumulator_overflow_flag,
   output logic timer_wrap_flag
);

   itm_pkg::itm_ctrl_type ctrl_q;
   itm_pkg::itm_cfg_type cfg_q;

   logic [ADDR_W-1:0] awaddr_q;
   logic aw_held_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic w_held_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic do_write;
   logic do_read;
   logic status_read;

   logic [3:0] sync_level;
   logic [3:0] sync_rise;
   logic hold_rise;
   logic mod_rise;

   logic sinc_en_q;
   logic sync_start_q;
   logic restart;
   logic bypass;
   logic signed [31:0] sample;
   logic sample_valid;
   logic signed [31:0] acc_q;
   logic signed [32:0] sum;
   logic ovf_os;
   logic ovf_sh;
   logic ovf;
   logic [7:0] count_q;
   logic [7:0] eff_ratio;
   logic period_end;
   logic [31:0] data_q;
   logic data_new_q;
   logic ovf_flag_q;
   logic wrap_flag_q;
   logic wrap_pulse;
   logic [31:0] shifted;
   logic [4:0] shift_amt;
   logic [15:0] time_q;

   // ------------------------------------------------------------ bus slave
   assign s_axi_awready = clk_en & ~aw_held_q & ~bvalid_q;
   assign s_axi_wready = clk_en & ~w_held_q & ~bvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = clk_en & ~rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign do_write = clk_en & aw_held_q & w_held_q & ~bvalid_q;
   assign do_read = s_axi_arvalid & s_axi_arready;
   assign status_read = do_read & (s_axi_araddr == itm_pkg::ADDR_STATUS);

   // byte lane merge for writes
   function automatic logic [31:0] itm_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            res[8*i +: 8] = new_v[8*i +: 8];
      end
      return res;
   endfunction : itm_merge

   // address and data are taken in either order and held until both exist
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
      end
      else if (clk_en)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         else if (do_write)
            aw_held_q <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         else if (do_write)
            w_held_q <= 1'b0;
      end
   end

   // register writes and write response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_q <= itm_pkg::CTRL_RESET;
         cfg_q <= itm_pkg::CFG_RESET;
         bvalid_q <= 1'b0;
         bresp_q <= itm_pkg::RESP_OKAY;
      end
      else if (clk_en)
      begin
         if (do_write)
         begin
            bvalid_q <= 1'b1;
            bresp_q <= itm_pkg::RESP_OKAY;
            case (awaddr_q)
               itm_pkg::ADDR_CTRL:
                  ctrl_q <= itm_pkg::CTRL_W'(itm_merge(32'(ctrl_q), wdata_q, wstrb_q));
               itm_pkg::ADDR_CFG:
                  cfg_q <= itm_pkg::CFG_W'(itm_merge(32'(cfg_q), wdata_q, wstrb_q));
               itm_pkg::ADDR_STATUS, itm_pkg::ADDR_DATA, itm_pkg::ADDR_TIME:
                  bresp_q <= itm_pkg::RESP_OKAY; // read-only, write ignored
               default:
                  bresp_q <= itm_pkg::RESP_SLVERR;
            endcase
         end
         else if (bvalid_q && s_axi_bready)
            bvalid_q <= 1'b0;
      end
   end

   // read data captured at the address handshake
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= itm_pkg::RESP_OKAY;
      end
      else if (clk_en)
      begin
         if (do_read)
         begin
            rvalid_q <= 1'b1;
            rresp_q <= itm_pkg::RESP_OKAY;
            case (s_axi_araddr)
               itm_pkg::ADDR_CTRL: rdata_q <= 32'(ctrl_q);
               itm_pkg::ADDR_CFG: rdata_q <= 32'(cfg_q);
               itm_pkg::ADDR_STATUS:
               begin
                  rdata_q <= 32'h00000000;
                  rdata_q[itm_pkg::STAT_OVF_BIT] <= ovf_flag_q;
                  rdata_q[itm_pkg::STAT_WRAP_BIT] <= wrap_flag_q;
                  rdata_q[itm_pkg::STAT_DEMOD_BIT] <= demod_active;
               end
               itm_pkg::ADDR_DATA: rdata_q <= data_out;
               itm_pkg::ADDR_TIME: rdata_q <= 32'(time_q);
               default:
               begin
                  rdata_q <= 32'h00000000;
                  rresp_q <= itm_pkg::RESP_SLVERR;
               end
            endcase
         end
         else if (rvalid_q && s_axi_rready)
            rvalid_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------ pin inputs
   itm_edge_sync #(
      .WIDTH(4)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .clk_en(clk_en),
      .async_in({mod_data, mod_clk, hold_strobe_input}),
      .level_out(sync_level),
      .rise_out(sync_rise)
   );

   // chosen strobe edge and modulator clock edge
   assign hold_rise = ctrl_q.hold_source_select ? sync_rise[1] : sync_rise[0];
   assign mod_rise = sync_rise[2];

   // ------------------------------------------------------------ integrator
   // bypass only with the documented first-order, ratio one setup
   assign bypass = ctrl_q.sinc_path_on && (ctrl_q.sinc_order == itm_pkg::ORDER_FIRST)
                   && (cfg_q.sinc_ratio == 9'h001); // see (RULE14)

   // raw bit maps to plus or minus one at each rising modulator clock edge
   always_comb
   begin
      if (bypass)
      begin
         sample = sync_level[3] ? 32'sh00000001 : 32'shFFFFFFFF; // see (RULE14)
         sample_valid = mod_rise;
      end
      else
      begin
         sample = sinc_data;
         sample_valid = sinc_valid & clk_en; // see (RULE6)
      end
   end

   // start conditions remembered for edge detection
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sinc_en_q <= 1'b0;
         sync_start_q <= 1'b0;
      end
      else if (clk_en)
      begin
         sinc_en_q <= sinc_enable;
         sync_start_q <= ctrl_q.module_sync_start;
      end
   end

   assign sync_start_pulse = clk_en & ctrl_q.module_sync_start & ~sync_start_q; // see (RULE8)
   assign restart = sync_start_pulse
                    | (clk_en & sinc_enable & ~sinc_en_q
                       & ~ctrl_q.accumulate_mode_select); // see (RULE7)

   // ratio zero behaves as one, anything above the maximum is clamped
   assign eff_ratio = (cfg_q.accumulate_ratio == 8'h00) ? 8'h01 :
                      (cfg_q.accumulate_ratio > 8'(MAX_RATIO)) ? 8'(MAX_RATIO) :
                      cfg_q.accumulate_ratio; // see (RULE5)
   assign period_end = (count_q == eff_ratio - 8'h01);

   // 33-bit sum exposes both signed limits
   assign sum = 33'(acc_q) + 33'(sample); // see (RULE1)
   assign ovf_os = (sum >= 33'sh07FFFFFFF) || (sum <= -33'sh080000000); // see (RULE9)
   assign ovf_sh = (sum > 33'sh07FFFFFFF) || (sum < -33'sh080000000); // see (RULE10)
   assign ovf = sample_valid && ctrl_q.integrator_on &&
                (ctrl_q.accumulate_mode_select ? ovf_sh : ovf_os);

   // accumulator, sample count and output word
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         acc_q <= 32'sh00000000;
         count_q <= 8'h00;
         data_q <= 32'h00000000;
         data_new_q <= 1'b0;
      end
      else if (clk_en)
      begin
         data_new_q <= 1'b0;
         if (!ctrl_q.integrator_on)
         begin
            acc_q <= 32'sh00000000; // see (RULE2)
            count_q <= 8'h00;
            if (sample_valid)
            begin
               data_q <= sample; // see (RULE2)
               data_new_q <= 1'b1;
            end
         end
         else if (restart)
         begin
            acc_q <= 32'sh00000000; // see (RULE8)
            count_q <= 8'h00;
         end
         else if (ctrl_q.accumulate_mode_select) // see (RULE3)
         begin
            // hold edge reports the sum gathered so far; a sample in the same
            // cycle starts the next period instead of being dropped
            if (hold_rise)
            begin
               data_q <= acc_q; // see (RULE4)
               data_new_q <= 1'b1;
               acc_q <= sample_valid ? sample : 32'sh00000000; // see (RULE4)
            end
            else if (ovf)
               acc_q <= 32'sh00000000; // see (RULE11)
            else if (sample_valid)
               acc_q <= sum[31:0];
            count_q <= 8'h00;
         end
         else if (sample_valid)
         begin
            if (period_end)
            begin
               data_q <= sum[31:0]; // see (RULE5)
               data_new_q <= 1'b1;
               acc_q <= 32'sh00000000;
               count_q <= 8'h00;
            end
            else
            begin
               acc_q <= ovf ? 32'sh00000000 : sum[31:0]; // see (RULE11)
               count_q <= count_q + 8'h01;
            end
         end
      end
   end

   // ------------------------------------------------------------ output window
   // shift beyond sixteen would pull copies of the sign bit into the 15-bit window, so it is capped
   assign shift_amt = (16'(cfg_q.left_move_count) > itm_pkg::SHIFT_MAX) ?
                      5'(itm_pkg::SHIFT_MAX) : cfg_q.left_move_count;
   assign shifted = 32'($signed(data_q) >>> shift_amt); // see (RULE12)
   assign data_out = ctrl_q.wide_output_select ? data_q :
                     {{16{data_q[31]}}, data_q[31], shifted[14:0]}; // see (RULE13)
   assign data_new = data_new_q;

   // ------------------------------------------------------------ time measure
   itm_time_counter #(
      .WIDTH(itm_pkg::TIME_W)
   ) u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .clk_en(clk_en),
      .tick(ctrl_q.timer_kind_select ? mod_rise : clk_en), // see (RULE16)
      .capture(hold_rise), // see (RULE18)
      .clear(~ctrl_q.timer_kind_select & data_new_q), // see (RULE20)
      .time_q(time_q),
      .wrap_pulse(wrap_pulse)
   );
   assign time_out = time_q;

   // sticky flags: a new event in the clearing read's cycle wins
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ovf_flag_q <= 1'b0;
         wrap_flag_q <= 1'b0;
      end
      else if (clk_en)
      begin
         if (ovf)
            ovf_flag_q <= 1'b1; // see (RULE9)
         else if (status_read)
            ovf_flag_q <= 1'b0;
         if (wrap_pulse)
            wrap_flag_q <= 1'b1; // see (RULE21)
         else if (status_read)
            wrap_flag_q <= 1'b0; // see (RULE21)
      end
   end

   assign accumulator_overflow_flag = ovf_flag_q;
   assign timer_wrap_flag = wrap_flag_q;
   // demodulation path gated by enable and calibration
   assign demod_active = ctrl_q.demod_on & phase_cal_done; // see (RULE15)

endmodule : itm_channel

// ===== rtl/itm_edge_sync.sv
/*
 two-flop synchroniser with rising edge detection for a group of bits.
 assumes inputs are asynchronous levels, each slower than half of aclk.
*/
`timescale 1ns/1ns
module itm_edge_sync #(
   parameter int WIDTH = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] level_out,
   output logic [WIDTH-1:0] rise_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] prev_q;

   // first stage read only by second stage
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end
      else if (clk_en)
      begin
         meta_q <= async_in; // see (RULE22)
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // one pulse per rising edge, gated by the enable so a frozen block sees none
   assign rise_out = sync_q & ~prev_q & {WIDTH{clk_en}}; // see (RULE22)
   assign level_out = sync_q;

endmodule : itm_edge_sync

// ===== rtl/itm_pkg.sv
/*
 package for the integrator and time measure channel: register map of the
 AXI4-Lite slave, control field layouts, reset values and widths.
 assumes one 32-bit AXI4-Lite data bus with word-aligned registers.
*/
// Functional notes
// (RULE1) integrator is 32-bit signed running accumulator
// (RULE2) integrator off: cleared, input passed straight through
// (RULE3) mode bit: 1 hold strobe, 0 sample count
// (RULE4) hold edge copies sum out, clears accumulator
// (RULE5) oversampling sums ratio samples, 1 to 128
// (RULE6) one sample per sinc output word only
// (RULE7) sinc enable starts a fresh oversampling cycle
// (RULE8) sync start rising edge restarts all accumulators
// (RULE9) oversampling overflow when magnitude reaches maximum
// (RULE10) hold mode overflow beyond either signed limit
// (RULE11) overflow clears accumulator, integration keeps going
// (RULE12) narrow output is bits 15+shift down to shift; the code keeps bits 14+shift down to shift under the sign bit
// (RULE13) narrow output sign always full word sign
// (RULE14) bypass setup feeds raw modulator bits in
// (RULE15) demodulation only when on and calibrated
// (RULE16) timer counts modulator or system clock cycles
// (RULE17) time counter spans 65536 counts
// (RULE18) kind 1 counts modulator clocks between hold edges
// (RULE19) hold edge loads time, restarts counter
// (RULE20) kind 0 counts system clocks from new data
// (RULE21) wrap flag on top-to-zero, cleared by status read
// (RULE22) strobes and modulator clock synchronised before edges
package itm_pkg;

   // register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CFG = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_DATA = 8'h0C;
   localparam logic [7:0] ADDR_TIME = 8'h10;

   // status bit positions
   localparam int STAT_OVF_BIT = 0;
   localparam int STAT_WRAP_BIT = 1;
   localparam int STAT_DEMOD_BIT = 2;

   // widths
   localparam int ACC_W = 32;
   localparam int TIME_W = 16;
   localparam int CTRL_W = 10;
   localparam int CFG_W = 22;

   // sinc structure code meaning first order
   localparam logic [1:0] ORDER_FIRST = 2'h0;

   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // control word, msb field first
   typedef struct packed {
      logic [1:0] sinc_order;
      logic sinc_path_on;
      logic module_sync_start;
      logic demod_on;
      logic timer_kind_select;
      logic wide_output_select;
      logic hold_source_select;
      logic accumulate_mode_select;
      logic integrator_on;
   } itm_ctrl_type;

   // configuration word, msb field first
   typedef struct packed {
      logic [4:0] left_move_count;
      logic [8:0] sinc_ratio;
      logic [7:0] accumulate_ratio;
   } itm_cfg_type;

   localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;
   localparam logic [CFG_W-1:0] CFG_RESET = 22'h000101;
   localparam logic [15:0] SHIFT_MAX = 16'h0010;

endpackage : itm_pkg

// ===== rtl/itm_time_counter.sv
/*
 16-bit time measure counter with capture register and wrap pulse.
 assumes capture and clear are single-cycle pulses on aclk, tick a per-cycle count enable.
*/
`timescale 1ns/1ns
module itm_time_counter #(
   parameter int WIDTH = itm_pkg::TIME_W
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic tick,
   input wire logic capture,
   input wire logic clear,
   output logic [WIDTH-1:0] time_q,
   output logic wrap_pulse
);

   logic [WIDTH-1:0] count_q;

   // capture wins over clear so a hold edge always reports
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         count_q <= '0;
         time_q <= '0;
      end
      else if (clk_en)
      begin
         if (capture)
         begin
            time_q <= count_q; // see (RULE19)
            count_q <= '0;
         end
         else if (clear)
            count_q <= '0; // see (RULE20)
         else if (tick)
            count_q <= count_q + 1'b1; // see (RULE17)
      end
   end

   // wrap from all ones to zero on a plain tick
   assign wrap_pulse = clk_en & tick & ~capture & ~clear & (&count_q); // see (RULE21)

endmodule : itm_time_counter

// ===== verification/itm_channel_sva.sv
/*
 checker for the channel: bus handshakes, sync pulse, demod gate, sticky flags.
 assumes it is bound to itm_channel and sees only that module's ports.
*/
`timescale 1ns/1ns
module itm_channel_sva #(
   parameter int ADDR_W = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic phase_cal_done,
   input wire logic demod_active,
   input wire logic sync_start_pulse,
   input wire logic accumulator_overflow_flag,
   input wire logic timer_wrap_flag
);
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // a taken status read is the only thing allowed to drop a flag
   wire logic stat_rd = s_axi_arvalid && s_axi_arready
      && (s_axi_araddr == ADDR_W'(itm_pkg::ADDR_STATUS));

   // both write halves taken on one edge
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence

   AST_WR_RESP: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response late");
   AST_WR_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   AST_RD_RESP: assert property (s_rd_taken |=> s_axi_rvalid)
      else $error("read data not one cycle after request");
   AST_RD_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   AST_SYNC_PULSE: assert property (sync_start_pulse |=> !sync_start_pulse)
      else $error("sync start pulse longer than one cycle");
   AST_DEMOD_GATE: assert property (demod_active |-> phase_cal_done)
      else $error("demodulation active before calibration");
   AST_OVF_STICKY: assert property (accumulator_overflow_flag && !stat_rd
      |=> accumulator_overflow_flag)
      else $error("overflow flag dropped without status read");
   AST_WRAP_STICKY: assert property (timer_wrap_flag && !stat_rd |=> timer_wrap_flag)
      else $error("wrap flag dropped without status read");
endmodule : itm_channel_sva

bind itm_channel itm_channel_sva #(.ADDR_W(ADDR_W)) u_sva (.*);

// ===== verification/itm_sinc_model.sv
/*
 model of the sinc stage and the modulator pins feeding the channel.
 assumes aclk from the bench; the bench calls its tasks.
*/
`timescale 1ns/1ns
module itm_sinc_model (
   input wire logic aclk,
   output logic [31:0] sinc_data,
   output logic sinc_valid,
   output logic mod_clk,
   output logic mod_data
);
   initial
   begin
      sinc_data = 32'h0;
      sinc_valid = 1'b0;
      mod_clk = 1'b0;
      mod_data = 1'b0;
   end

   // one output word, valid for a single cycle
   task automatic word(input logic [31:0] v);
      @(posedge aclk);
      sinc_data <= v;
      sinc_valid <= 1'b1;
      @(posedge aclk);
      sinc_data <= ~v; // stale word is not held on the bus
      sinc_valid <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask : word

   // n modulator periods carrying bit b; clock parked low between frames
   task automatic bits(input int n, input logic b);
      repeat (n)
      begin
         @(posedge aclk);
         mod_data <= b;
         repeat (4) @(posedge aclk);
         mod_clk <= 1'b1;
         repeat (4) @(posedge aclk);
         mod_clk <= 1'b0;
      end
      repeat (6) @(posedge aclk);
      mod_data <= ~b;
   endtask : bits
endmodule : itm_sinc_model

// ===== verification/tb_integrator_time_measure.sv
/*
 self-checking bench for itm_channel, registers reached over AXI4-Lite.
 assumes itm_pkg, the design and itm_sinc_model are compiled first.
*/
`timescale 1ns/1ns
module tb_integrator_time_measure;
   logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, sinc_data, data_out;
   logic sinc_valid, mod_clk, mod_data, data_new;
   logic sinc_enable = 1'b0, phase_cal_done = 1'b0;
   logic [1:0] hold_strobe_input = 2'h0;
   logic [15:0] time_out;
   logic demod_active, sync_start_pulse, accumulator_overflow_flag, timer_wrap_flag;
   int err_total = 0, n_checks = 0;
   int rt[3] = '{1, 3, 128};
   int sh[3] = '{1, 9, 14};
   logic [31:0] d;
   logic [1:0] r;

   itm_channel u_dut (.*);
   itm_sinc_model u_src (.*);

   // 50 MHz clock
   always #10 aclk = ~aclk;

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // ready sampled at the falling edge, so it is settled for the next rising one
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int t;
      logic ta, tw, hit;
      t = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         hit = s_axi_bvalid;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         t++;
      end while (!hit && t < 50);
      s_axi_bready <= 1'b0;
      if (!hit) err_total++;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] rs);
      int t;
      logic ta, hit;
      t = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(negedge aclk);
         ta = s_axi_arvalid && s_axi_arready;
         hit = s_axi_rvalid;
         q = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
         t++;
      end while (!hit && t < 50);
      s_axi_rready <= 1'b0;
      if (!hit) err_total++;
   endtask : rd

   task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      logic [1:0] rs;
      rd(a, q, rs);
      chk(n, e, q);
   endtask : rc

   task automatic hold(input int i);
      @(posedge aclk);
      hold_strobe_input[i] <= 1'b1;
      repeat (6) @(posedge aclk);
      hold_strobe_input[i] <= 1'b0;
      repeat (6) @(posedge aclk);
   endtask : hold

   // config, then a rising sync bit restarts the sum
   task automatic go(input logic [31:0] c, input logic [31:0] g);
      wr(itm_pkg::ADDR_CFG, g);
      wr(itm_pkg::ADDR_CTRL, c);
      wr(itm_pkg::ADDR_CTRL, c | 32'h40);
   endtask : go

   // narrow word: sign on top, 15 window bits from the shift upward
   function automatic logic [31:0] narrow(input logic [31:0] v, input int s);
      return {{17{v[31]}}, v[s +: 15]};
   endfunction : narrow

   task automatic conclude;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude

   // watchdog sized above the long wrap wait
   initial
   begin
      repeat (90000) @(posedge aclk);
      err_total++;
      conclude();
   end

   initial
   begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rc("ctrl", itm_pkg::ADDR_CTRL, 32'h0);
      rc("cfg", itm_pkg::ADDR_CFG, 32'h101);
      rd(8'h14, d, r);
      chk("unmapped", {30'h0, itm_pkg::RESP_SLVERR}, {30'h0, r});
      wr(itm_pkg::ADDR_CTRL, 32'h8);
      u_src.word(32'h0000_1234);
      rc("pass", itm_pkg::ADDR_DATA, 32'h1234);
      foreach (rt[k])
      begin
         go(32'h9, 32'(rt[k]));
         repeat (rt[k]) u_src.word(32'h2);
         rc("sum", itm_pkg::ADDR_DATA, 32'(2 * rt[k]));
      end
      foreach (sh[k])
      begin
         go(32'h1, 32'((sh[k] << 17) | 1));
         u_src.word(32'hF2A5_C3E1);
         rc("narrow", itm_pkg::ADDR_DATA, narrow(32'hF2A5_C3E1, sh[k]));
      end
      // overflow on the first word, then three more words
      go(32'h9, 32'h4);
      u_src.word(32'h7FFF_FFFF);
      repeat (3) u_src.word(32'h5);
      rc("ovf", itm_pkg::ADDR_STATUS, 32'h1);
      rc("ovf clr", itm_pkg::ADDR_STATUS, 32'h0);
      rc("after ovf", itm_pkg::ADDR_DATA, 32'd15);
      u_src.word(32'h5);
      sinc_enable <= 1'b1;
      clk_en <= 1'b0;
      u_src.word(32'h9);
      clk_en <= 1'b1;
      repeat (4) u_src.word(32'h3);
      rc("restart", itm_pkg::ADDR_DATA, 32'd12);
      // hold mode on strobe 1, timer on modulator clocks; strobe 0 ignored
      wr(itm_pkg::ADDR_CTRL, 32'h1F);
      hold(1);
      u_src.word(32'h5);
      hold(0);
      u_src.word(32'h6);
      u_src.bits(5, 1'b1);
      hold(1);
      rc("hold", itm_pkg::ADDR_DATA, 32'd11);
      rc("time", itm_pkg::ADDR_TIME, 32'd5);
      chk("time pin", 32'd5, 32'(time_out));
      u_src.word(32'h7FFF_FFFF);
      u_src.word(32'h1);
      rc("hold ovf", itm_pkg::ADDR_STATUS, 32'h1);
      go(32'h89, 32'h104);
      u_src.bits(4, 1'b1);
      rc("raw up", itm_pkg::ADDR_DATA, 32'd4);
      u_src.bits(4, 1'b0);
      rc("raw down", itm_pkg::ADDR_DATA, 32'hFFFF_FFFC);
      wr(itm_pkg::ADDR_CTRL, 32'h20);
      @(negedge aclk);
      chk("demod off", 32'h0, {31'h0, demod_active});
      @(posedge aclk);
      phase_cal_done <= 1'b1;
      @(negedge aclk);
      chk("demod on", 32'h1, {31'h0, demod_active});
      rc("demod stat", itm_pkg::ADDR_STATUS, 32'h4);
      // system clock count with no new data runs past 16 bits
      wr(itm_pkg::ADDR_CTRL, 32'h0);
      repeat (65600) @(posedge aclk);
      rc("wrap", itm_pkg::ADDR_STATUS, 32'h2);
      rc("wrap clr", itm_pkg::ADDR_STATUS, 32'h0);
      conclude();
   end
endmodule : tb_integrator_time_measure
